// *** hdl/tcp_regs.vh ***
// register map, codes and timing constants of the three-channel pwm block
`ifndef TCP_REGS_VH
`define TCP_REGS_VH
`define TCP_REG_FREQ 3'h0
`define TCP_REG_DUTY 3'h1
`define TCP_REG_CNTEN 3'h2
`define TCP_REG_PRE_HI 3'h3
`define TCP_REG_PRE_LO 3'h4
`define TCP_REG_RUN_HI 3'h5
`define TCP_REG_RUN_LO 3'h6
`define TCP_REG_ERR 3'h7
`define TCP_REG_FLAGS 3'h0
`define TCP_BANK_FLAGS 2'h3
`define TCP_FLAG_RUN 0
`define TCP_FLAG_DONE 1
`define TCP_FLAG_OVF 2
`define TCP_PERIOD0_NS 69010000
`define TCP_PERIOD1_NS 21760000
`define TCP_PERIOD2_NS 2720000
`define TCP_CLK_NS 10
`define TCP_FREQ_MAX 16'h0002
`define TCP_DUTY_MIN 16'h0001
`define TCP_DUTY_MAX 16'h0064
`define TCP_CNTEN_MAX 16'h0001
`define TCP_PRESET_MIN 32'h00000001
`define TCP_PRESET_MAX 32'h05F5E100
`define TCP_ERR_OK 16'h0000
`define TCP_ERR_FREQ 16'h0001
`define TCP_ERR_DUTY 16'h0002
`define TCP_ERR_CNTEN 16'h0003
`define TCP_ERR_PRESET 16'h0004
`define TCP_ERR_CHB 16'h0005
`define TCP_SCAN_CYC 1000
`define TCP_PCT_FULL 32'h00000064
`endif

// *** hdl/tcp_channel.v ***
// one pwm channel: parameter check, period/duty timing, pulse counting, flags
`timescale 1ns/1ps
`include "tcp_regs.vh"
module tcp_channel #(
   parameter COUNT_OK = 1,
   parameter [31:0] PERIOD0_CYC = `TCP_PERIOD0_NS / `TCP_CLK_NS,
   parameter [31:0] PERIOD1_CYC = `TCP_PERIOD1_NS / `TCP_CLK_NS,
   parameter [31:0] PERIOD2_CYC = `TCP_PERIOD2_NS / `TCP_CLK_NS,
   parameter [31:0] SCAN_CYC = `TCP_SCAN_CYC
) (
   input wire i_core_clk, // core clock
   input wire i_rst_n, // synchronous reset, active low
   input wire i_start, // synchronised start level
   input wire [15:0] i_freq, // frequency select word
   input wire [15:0] i_duty, // duty percent word
   input wire [15:0] i_cnten, // counting enable word
   input wire [31:0] i_preset, // preset pulse total
   output reg o_pwm, // pulse output
   output reg [31:0] o_count, // pulses emitted, scan-refreshed
   output reg [15:0] o_err, // error code
   output reg o_run, // running flag
   output reg o_done, // complete flag
   output reg o_ovf // overflow flag
);
   reg start_q;
   reg counted_q;
   reg [31:0] period_q;
   reg [31:0] high_q;
   reg [31:0] phase_q;
   reg [31:0] emitted_q;
   reg [31:0] scan_q;
   reg [15:0] err_d;
   wire rise = i_start & ~start_q;
   wire fall = ~i_start & start_q;
   wire scan_tick = (scan_q == SCAN_CYC - 32'h00000001);
   wire period_end = (phase_q == period_q - 32'h00000001);

   // first failing check wins, in code order
   always @* begin
      err_d = `TCP_ERR_OK;
      if (i_freq > `TCP_FREQ_MAX)
         err_d = `TCP_ERR_FREQ;
      else if (i_duty < `TCP_DUTY_MIN || i_duty > `TCP_DUTY_MAX)
         err_d = `TCP_ERR_DUTY;
      else if (i_cnten > `TCP_CNTEN_MAX)
         err_d = `TCP_ERR_CNTEN;
      else if (i_cnten == `TCP_CNTEN_MAX && COUNT_OK == 0)
         err_d = `TCP_ERR_CHB;
      else if (i_cnten == `TCP_CNTEN_MAX &&
               (i_preset < `TCP_PRESET_MIN || i_preset > `TCP_PRESET_MAX))
         err_d = `TCP_ERR_PRESET;
   end

   function [31:0] tcp_period;
      input [15:0] sel;
      begin
         case (sel[1:0])
            2'h0: tcp_period = PERIOD0_CYC;
            2'h1: tcp_period = PERIOD1_CYC;
            default: tcp_period = PERIOD2_CYC;
         endcase
      end
   endfunction

   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         start_q <= 1'b0;
         counted_q <= 1'b0;
         period_q <= 32'h00000001;
         high_q <= 32'h00000000;
         phase_q <= 32'h00000000;
         emitted_q <= 32'h00000000;
         scan_q <= 32'h00000000;
         o_pwm <= 1'b0;
         o_count <= 32'h00000000;
         o_err <= `TCP_ERR_OK;
         o_run <= 1'b0;
         o_done <= 1'b0;
         o_ovf <= 1'b0;
      end else begin
         start_q <= i_start;
         scan_q <= scan_tick ? 32'h00000000 : scan_q + 32'h00000001;
         if (rise) begin
            o_err <= err_d;
            o_done <= 1'b0;
            o_ovf <= 1'b0;
            if (err_d == `TCP_ERR_OK) begin
               counted_q <= i_cnten[0];
               period_q <= tcp_period(i_freq);
               high_q <= (tcp_period(i_freq) / `TCP_PCT_FULL) * {16'h0000, i_duty};
               phase_q <= 32'h00000000;
               emitted_q <= 32'h00000000;
               o_count <= 32'h00000000;
               o_run <= 1'b1;
               o_pwm <= 1'b1;
            end
         end else if (fall && o_run) begin
            o_run <= 1'b0;
            o_done <= 1'b1;
            o_pwm <= 1'b0;
         end else if (o_run) begin
            // duty is re-sampled at scan boundaries only
            if (scan_tick)
               high_q <= (period_q / `TCP_PCT_FULL) * {16'h0000, i_duty};
            if (scan_tick)
               o_count <= emitted_q;
            if (period_end) begin
               phase_q <= 32'h00000000;
               emitted_q <= emitted_q + 32'h00000001;
               if (counted_q && emitted_q + 32'h00000001 >= i_preset) begin
                  o_run <= 1'b0;
                  o_done <= 1'b1;
                  o_pwm <= 1'b0;
                  o_count <= emitted_q + 32'h00000001;
                  o_ovf <= (emitted_q + 32'h00000001 > i_preset);
               end else begin
                  o_pwm <= 1'b1;
               end
            end else begin
               phase_q <= phase_q + 32'h00000001;
               o_pwm <= (phase_q + 32'h00000001 < high_q);
            end
         end
      end
   end
endmodule // tcp_channel

// *** hdl/tcp_top.v ***
// three-channel duty pulse generator with register port
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "tcp_regs.vh"
// What this block does
// - frequency select picks one of three periods
// - duty percent 1 to 100 sets high time
// - counting enable 0 or 1, A and C
// - uncounted channel pulses while start held
// - counted preset 32 bits, 1 to 100000000
// - running count refreshed every scan
// - count, error and flags are read only
// - parameters checked on start rising
// - error codes 0 to 5 reported
// - running flag while pulses produced
// - complete flag on finish or stop
// - overflow flag when count exceeds preset
// - reaching preset stops output, sets complete
// - start dropping halts output at once
// - duty change takes effect next scan
// - eight words per channel, three flags
// - channel A drives A, B drives B
// - channel C drives output C alike
module tcp_top #(
   parameter [31:0] PERIOD0_CYC = `TCP_PERIOD0_NS / `TCP_CLK_NS,
   parameter [31:0] PERIOD1_CYC = `TCP_PERIOD1_NS / `TCP_CLK_NS,
   parameter [31:0] PERIOD2_CYC = `TCP_PERIOD2_NS / `TCP_CLK_NS,
   parameter [31:0] SCAN_CYC = `TCP_SCAN_CYC
) (
   input wire i_core_clk, // 100 MHz clock
   input wire i_rst_n, // synchronous reset, active low
   input wire [4:0] i_addr, // word address: bank[4:3], word[2:0]
   input wire [15:0] i_wdata, // write data
   input wire i_wr, // write strobe
   input wire i_rd, // read strobe
   output reg [15:0] o_rdata, // read data, cycle after strobe
   input wire [2:0] i_start, // start pins a,b,c (asynchronous)
   output wire o_output_a, // channel a pulse output
   output wire o_output_b, // channel b pulse output
   output wire o_output_c // channel c pulse output
);
   reg [2:0] s1_q;
   reg [2:0] s2_q;
   reg [2:0] s3_q;
   reg [2:0] start_q;
   reg [15:0] freq_q [0:2];
   reg [15:0] duty_q [0:2];
   reg [15:0] cnten_q [0:2];
   reg [15:0] prehi_q [0:2];
   reg [15:0] prelo_q [0:2];
   wire [2:0] pwm;
   wire [31:0] cnt [0:2];
   wire [15:0] err [0:2];
   wire [2:0] run;
   wire [2:0] done;
   wire [2:0] ovf;
   integer k;
   integer j;

   // start pins pass three flops; level accepted once stages 2 and 3 agree
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
         start_q <= 3'h0;
      end else begin
         s1_q <= i_start;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (k = 0; k < 3; k = k + 1)
            if (s2_q[k] == s3_q[k])
               start_q[k] <= s3_q[k];
      end
   end

   // only parameter words are writable; others ignore writes
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         // separate loop index so each process owns its own variable
         for (j = 0; j < 3; j = j + 1) begin
            freq_q[j] <= 16'h0000;
            duty_q[j] <= 16'h0000;
            cnten_q[j] <= 16'h0000;
            prehi_q[j] <= 16'h0000;
            prelo_q[j] <= 16'h0000;
         end
      end else if (i_wr && i_addr[4:3] != `TCP_BANK_FLAGS) begin
         case (i_addr[2:0])
            `TCP_REG_FREQ: freq_q[i_addr[4:3]] <= i_wdata;
            `TCP_REG_DUTY: duty_q[i_addr[4:3]] <= i_wdata;
            `TCP_REG_CNTEN: cnten_q[i_addr[4:3]] <= i_wdata;
            `TCP_REG_PRE_HI: prehi_q[i_addr[4:3]] <= i_wdata;
            `TCP_REG_PRE_LO: prelo_q[i_addr[4:3]] <= i_wdata;
            default: ;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : ch
         tcp_channel #(
            .COUNT_OK(g != 1),
            .PERIOD0_CYC(PERIOD0_CYC),
            .PERIOD1_CYC(PERIOD1_CYC),
            .PERIOD2_CYC(PERIOD2_CYC),
            .SCAN_CYC(SCAN_CYC)
         ) u_ch (
            .i_core_clk(i_core_clk),
            .i_rst_n(i_rst_n),
            .i_start(start_q[g]),
            .i_freq(freq_q[g]),
            .i_duty(duty_q[g]),
            .i_cnten(cnten_q[g]),
            .i_preset({prehi_q[g], prelo_q[g]}),
            .o_pwm(pwm[g]),
            .o_count(cnt[g]),
            .o_err(err[g]),
            .o_run(run[g]),
            .o_done(done[g]),
            .o_ovf(ovf[g])
         );
      end
   endgenerate

   assign o_output_a = pwm[0];
   assign o_output_b = pwm[1];
   assign o_output_c = pwm[2];

   // bank 3 word n holds the three flags of channel n; unmapped reads zero
   always @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= 16'h0000;
         if (i_addr[4:3] == `TCP_BANK_FLAGS) begin
            if (i_addr[2:0] < 3'h3)
               o_rdata <= {13'h0000, ovf[i_addr[1:0]], done[i_addr[1:0]],
                           run[i_addr[1:0]]};
         end else begin
            case (i_addr[2:0])
               `TCP_REG_FREQ: o_rdata <= freq_q[i_addr[4:3]];
               `TCP_REG_DUTY: o_rdata <= duty_q[i_addr[4:3]];
               `TCP_REG_CNTEN: o_rdata <= cnten_q[i_addr[4:3]];
               `TCP_REG_PRE_HI: o_rdata <= prehi_q[i_addr[4:3]];
               `TCP_REG_PRE_LO: o_rdata <= prelo_q[i_addr[4:3]];
               `TCP_REG_RUN_HI: o_rdata <= cnt[i_addr[4:3]][31:16];
               `TCP_REG_RUN_LO: o_rdata <= cnt[i_addr[4:3]][15:0];
               default: o_rdata <= err[i_addr[4:3]];
            endcase
         end
      end
   end
endmodule // tcp_top

// *** verif/tcp_top_monitor.sv ***
// port assertions for the three-channel pulse generator
`timescale 1ns/1ps
module tcp_top_monitor (
   input wire i_core_clk, // clock
   input wire i_rst_n, // reset
   input wire [4:0] i_addr, // address
   input wire [15:0] i_wdata, // wdata
   input wire i_wr, // write
   input wire i_rd, // read
   input wire [15:0] o_rdata, // rdata
   input wire [2:0] i_start, // starts
   input wire o_output_a, // out a
   input wire o_output_b, // out b
   input wire o_output_c // out c
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // start passes a synchroniser and an edge detect before the output reacts
   sequence s_idle(sig);
      (!sig) [*8];
   endsequence
   chk_reset_quiet: assert property (disable iff (1'b0) !i_rst_n |=>
      !(o_output_a | o_output_b | o_output_c)) else $error("output high after reset");
   chk_a_halts: assert property (s_idle(i_start[0]) |-> !o_output_a)
      else $error("output a without start");
   chk_b_halts: assert property (s_idle(i_start[1]) |-> !o_output_b)
      else $error("output b without start");
   chk_c_halts: assert property (s_idle(i_start[2]) |-> !o_output_c)
      else $error("output c without start");
   chk_high_min: assert property ($rose(o_output_a) |=> o_output_a)
      else $error("high phase too short");
   chk_rdata_hold: assert property (!$past(i_rd) |-> $stable(o_rdata))
      else $error("read data moved without read");
   chk_unmapped_zero: assert property (i_rd && i_addr == 5'h1B |=> o_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_err_range: assert property (i_rd && i_addr[4:3] != 2'h3 && i_addr[2:0] == 3'h7 |=>
      o_rdata <= 16'h0005) else $error("error code out of range");
endmodule // tcp_top_monitor
bind tcp_top tcp_top_monitor tcp_top_monitor_inst (.i_core_clk, .i_rst_n, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .i_start, .o_output_a, .o_output_b, .o_output_c);

// *** verif/tcp_load_model.sv ***
// load on one pulse output: counts pulses, measures high width and period
`timescale 1ns/1ps
module tcp_load_model (
   input wire i_core_clk, // clock
   input wire i_clr, // clear count
   input wire i_pwm, // pulse in
   output logic [31:0] o_pulses = 0, // rises seen
   output logic [31:0] o_high = 0, // last high width
   output logic [31:0] o_period = 0 // last rise spacing
);
   logic [31:0] hi_q = 0;
   logic [31:0] per_q = 0;
   logic prev_q = 0;
   always @(posedge i_core_clk) begin
      prev_q <= i_pwm;
      hi_q <= i_pwm ? hi_q + 1 : 0;
      per_q <= (i_pwm && !prev_q) ? 1 : per_q + 1;
      if (i_pwm && !prev_q) o_period <= per_q;
      if (!i_pwm && prev_q) o_high <= hi_q;
      if (i_clr) o_pulses <= 0;
      else if (i_pwm && !prev_q) o_pulses <= o_pulses + 1;
   end
endmodule // tcp_load_model

// *** verif/three_channel_duty_pulse_generator_tb_top.sv ***
// self-checking bench for the three-channel pulse generator
`timescale 1ns/1ps
module three_channel_duty_pulse_generator_tb_top;
   logic i_core_clk = 0, i_rst_n = 0, wr = 0, rd = 0, clr = 1;
   logic [4:0] addr = 0;
   logic [15:0] wdata = 0, v;
   wire [15:0] rdata;
   logic [2:0] start = 0;
   wire [2:0] pout;
   logic [31:0] pulses [3], hi [3], per [3];
   int mismatches = 0, n_checks = 0;
   always #5 i_core_clk = ~i_core_clk;
   // short periods keep the run small; expectations follow these values
   tcp_top #(.PERIOD0_CYC(200), .PERIOD1_CYC(300), .PERIOD2_CYC(400), .SCAN_CYC(10)) tcp_top_inst (
      .i_core_clk, .i_rst_n, .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_start(start), .o_output_a(pout[0]), .o_output_b(pout[1]),
      .o_output_c(pout[2]));
   for (genvar g = 0; g < 3; g++) begin : g_load
      tcp_load_model tcp_load_model_inst (.i_core_clk, .i_clr(clr), .i_pwm(pout[g]),
         .o_pulses(pulses[g]), .o_high(hi[g]), .o_period(per[g]));
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge i_core_clk);
      wr <= 0;
   endtask
   task automatic rd_reg(input logic [4:0] a);
      @(posedge i_core_clk);
      addr <= a;
      rd <= 1;
      @(posedge i_core_clk);
      rd <= 0;
      #1 v = rdata;
   endtask
   task automatic setup(input logic [1:0] ch, input logic [15:0] f, d, c, input logic [31:0] p);
      wr_reg({ch, 3'h0}, f);
      wr_reg({ch, 3'h1}, d);
      wr_reg({ch, 3'h2}, c);
      wr_reg({ch, 3'h3}, p[31:16]);
      wr_reg({ch, 3'h4}, p[15:0]);
   endtask
   // the wait covers the start synchroniser and edge detect; the load clear lasts one
   // cycle so that the first rise of a run is still counted
   task automatic go(input logic [1:0] ch, input logic lv);
      @(posedge i_core_clk);
      start[ch] <= lv;
      clr <= lv;
      @(posedge i_core_clk);
      clr <= 0;
      repeat (7) @(posedge i_core_clk);
   endtask
   task automatic flags(input logic [1:0] ch, input logic [2:0] e);
      rd_reg({3'h6, ch});
      chk(v, {13'h0, e});
   endtask
   task automatic cnt(input logic [1:0] ch, input logic [31:0] e);
      logic [31:0] c;
      rd_reg({ch, 3'h5});
      c[31:16] = v;
      rd_reg({ch, 3'h6});
      c[15:0] = v;
      chk(c, e);
   endtask
   task automatic wait_done(input logic [1:0] ch);
      rd_reg({3'h6, ch});
      for (int i = 0; i < 3000 && v !== 16'h0002; i++) rd_reg({3'h6, ch});
      chk(v, 16'h0002);
   endtask
   task automatic ecase(input logic [1:0] ch, input logic [15:0] f, d, c, input logic [31:0] p,
         input logic [15:0] e);
      setup(ch, f, d, c, p);
      go(ch, 1);
      rd_reg({ch, 3'h7});
      chk(v, e);
      flags(ch, {2'b00, e == 0});
      go(ch, 0);
   endtask
   initial begin
      repeat (20000) @(posedge i_core_clk);
      mismatches++;
      wrap_up;
   end
   initial begin
      repeat (5) @(posedge i_core_clk);
      i_rst_n <= 1;
      for (int i = 0; i < 3; i++) flags(i[1:0], 3'b000);
      rd_reg(5'h1B);
      chk(v, 0);
      ecase(0, 3, 50, 0, 0, 1);
      ecase(0, 0, 0, 0, 0, 2);
      ecase(0, 0, 101, 0, 0, 2);
      ecase(0, 0, 50, 2, 0, 3);
      ecase(0, 0, 50, 1, 0, 4);
      ecase(2, 0, 50, 1, 32'h05F5E101, 4);
      ecase(1, 0, 50, 1, 0, 5);
      ecase(2, 0, 50, 1, 32'h05F5E100, 0);
      setup(0, 2, 50, 1, 3);
      go(0, 1);
      wait_done(0);
      chk(pulses[0], 3);
      chk(hi[0], 200);
      chk(per[0], 400);
      cnt(0, 3);
      wr_reg(5'h07, 16'hFFFF);
      wr_reg(5'h05, 16'h1234);
      wr_reg(5'h18, 16'h0007);
      rd_reg(5'h07);
      chk(v, 0);
      cnt(0, 3);
      flags(0, 3'b010);
      go(0, 0);
      setup(0, 2, 50, 1, 1);
      go(0, 1);
      wait_done(0);
      cnt(0, 1);
      go(0, 0);
      // lowering the preset mid-run makes the emitted total exceed it
      setup(0, 2, 50, 1, 5);
      go(0, 1);
      repeat (500) @(posedge i_core_clk);
      wr_reg(5'h04, 16'h0001);
      repeat (400) @(posedge i_core_clk);
      flags(0, 3'b110);
      cnt(0, 2);
      setup(1, 0, 25, 0, 0);
      go(1, 1);
      repeat (450) @(posedge i_core_clk);
      chk(per[1], 200);
      chk(hi[1], 50);
      wr_reg(5'h09, 75);
      repeat (450) @(posedge i_core_clk);
      chk(hi[1], 150);
      flags(1, 3'b001);
      go(1, 0);
      chk(pout[1], 0);
      flags(1, 3'b010);
      setup(2, 1, 10, 1, 100);
      go(2, 1);
      repeat (572) @(posedge i_core_clk);
      go(2, 0);
      flags(2, 3'b010);
      chk(pulses[2], 2);
      chk(hi[2], 30);
      cnt(2, 1);
      wrap_up;
   end
endmodule // three_channel_duty_pulse_generator_tb_top
